//--- hdl/crp_duty_calc.sv
`timescale 1ns/10ps
module crp_duty_calc (
  // inputs
  input wire logic [crp_pkg::CNT_W-1:0] period_in,
  input wire logic [crp_pkg::DUTY_W-1:0] duty_in,
  // high time in cycles
  output logic [crp_pkg::CNT_W-1:0] high_out
);
  import crp_pkg::*;
  logic [CNT_W+DUTY_W-1:0] prod;
  always_comb begin
    prod = period_in * duty_in;
    high_out = CNT_W'(prod / RES_FINE); // RULE9
  end
endmodule : crp_duty_calc

//--- hdl/crp_period_rom.sv
`timescale 1ns/10ps
module crp_period_rom (
  // code in
  input wire logic [crp_pkg::CODE_W-1:0] code_in,
  // period out
  output logic [crp_pkg::CNT_W-1:0] period_out,
  output logic fine_out
);
  import crp_pkg::*;
  logic [CNT_W-1:0] table_q [NUM_CODES];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CODES; gi++) begin : g_rom
      assign table_q[gi] = CNT_W'(PERIOD_NS[gi] / CLK_PERIOD_NS); // RULE3
    end
  endgenerate
  always_comb begin
    if (code_in <= LAST_CODE) begin
      period_out = table_q[code_in];
    end else begin
      period_out = table_q[0];
    end
    fine_out = (code_in <= LAST_FINE_CODE); // RULE1 RULE2
  end
endmodule : crp_period_rom

//--- hdl/crp_pkg.sv
package crp_pkg;
  // clock and period table
  localparam int CLK_MHZ = 250;
  localparam int CODE_W = 5;
  localparam int DUTY_W = 10;
  localparam int CNT_W = 28;
  localparam int NUM_CODES = 25;
  localparam logic [CODE_W-1:0] LAST_FINE_CODE = 5'h13;
  localparam logic [CODE_W-1:0] LAST_CODE = 5'h18;
  localparam logic [DUTY_W-1:0] MAX_DUTY_FINE = 10'h3e7;
  localparam logic [DUTY_W-1:0] MAX_DUTY_COARSE = 10'h3de;
  localparam logic [DUTY_W-1:0] COARSE_STEP = 10'h00a;
  localparam logic [DUTY_W-1:0] RES_FINE = 10'h3e8;
  // periods in nanoseconds, one entry per code
  localparam int PERIOD_NS [NUM_CODES] = '{
    666670000, 502510000, 245700000, 163930000, 122850000, 102350000,
    51200000, 20480000, 10240000, 4960000, 2480000, 2000000, 1440000,
    960000, 800000, 640000, 480000, 320000, 160000, 80000,
    60000, 50000, 40000, 30000, 20000};
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CODE_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_W = 2;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_WRAP = 1;
  typedef enum logic [1:0] {
    CRP_IDLE = 2'h0,
    CRP_RUN = 2'h1,
    CRP_FAULT = 2'h2
  } crp_state_t;
endpackage : crp_pkg

//--- hdl/crp_pwm_top.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// RULE1 - codes 0-19 use duty 0..999 of 1000
// RULE2 - codes 20-24 duty 0..990, tenths dropped
// RULE3 - code picks period from 25-entry table
// RULE4 - code 1 half duty gives 502.5 ms
// RULE5 - output only while run input active
// RULE6 - bad duty while running clamps to max
// RULE7 - bad duty at start blocks, flags error
// RULE8 - controller assigns pin to pwm first
// RULE9 - high time is duty over resolution times period
module crp_pwm_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // run condition
  input wire logic pwm_run_input_in,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // pin and interrupt
  output logic pwm_output_pin_out,
  output logic irq_out
);
  import crp_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pin_enable;
    logic [CODE_W-1:0] code;
    logic [DUTY_W-1:0] duty;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    crp_state_t state;
    logic run_prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high;
    logic pin;
    logic [CNT_W-1:0] hi_len;
  } crp_regs_t;

  crp_regs_t r;
  crp_regs_t next_r;

  logic [CNT_W-1:0] rom_period;
  logic rom_fine;
  logic [CNT_W-1:0] calc_high;
  logic [DUTY_W-1:0] max_duty;
  logic duty_bad;
  logic [DUTY_W-1:0] eff_duty;
  logic wr_fire;
  logic rd_fire;
  logic map_w;
  logic map_r;
  logic [IRQ_W-1:0] irq_set;

  crp_period_rom u_rom (
    .code_in(r.code),
    .period_out(rom_period),
    .fine_out(rom_fine)
  );

  crp_duty_calc u_calc (
    .period_in(rom_period),
    .duty_in(eff_duty),
    .high_out(calc_high)
  );

  always_comb begin
    // duty range per resolution
    max_duty = rom_fine ? MAX_DUTY_FINE : MAX_DUTY_COARSE; // RULE1 RULE2
    duty_bad = (r.duty > max_duty) || (r.code > LAST_CODE);
    if (r.duty > max_duty) begin
      eff_duty = max_duty; // RULE6
    end else if (!rom_fine) begin
      eff_duty = DUTY_W'((r.duty / COARSE_STEP) * COARSE_STEP); // RULE2
    end else begin
      eff_duty = r.duty;
    end
  end

  always_comb begin
    next_r = r;
    irq_set = '0;
    s_axi_awready_out = !r.aw_got && !r.bvalid;
    s_axi_wready_out = !r.w_got && !r.bvalid;
    s_axi_arready_out = !r.rvalid;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata_in;
      next_r.w_strb = s_axi_wstrb_in;
    end
    wr_fire = r.aw_got && r.w_got;
    map_w = 1'b1;
    if (wr_fire) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      unique case (r.aw_addr)
        CTRL_OFS: begin
          if (r.w_strb[0]) next_r.pin_enable = r.w_data[0]; // RULE8
        end
        CODE_OFS: begin
          if (r.w_strb[0]) next_r.code = r.w_data[CODE_W-1:0];
        end
        DUTY_OFS: begin
          if (r.w_strb[0]) next_r.duty[7:0] = r.w_data[7:0];
          if (r.w_strb[1]) next_r.duty[DUTY_W-1:8] = r.w_data[DUTY_W-1:8];
        end
        STAT_OFS: begin
        end
        IRQ_OFS: begin
          if (r.w_strb[0]) next_r.irq_stat = r.irq_stat & ~r.w_data[IRQ_W-1:0];
        end
        MASK_OFS: begin
          if (r.w_strb[0]) next_r.irq_mask = r.w_data[IRQ_W-1:0];
        end
        default: map_w = 1'b0;
      endcase
      next_r.bresp = map_w ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready_in) begin
      next_r.bvalid = 1'b0;
    end
    rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    map_r = 1'b1;
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = '0;
      unique case (s_axi_araddr_in)
        CTRL_OFS: next_r.rdata[0] = r.pin_enable;
        CODE_OFS: next_r.rdata[CODE_W-1:0] = r.code;
        DUTY_OFS: next_r.rdata[DUTY_W-1:0] = r.duty;
        STAT_OFS: next_r.rdata[3:0] = {r.pin, rom_fine, r.state};
        IRQ_OFS: next_r.rdata[IRQ_W-1:0] = r.irq_stat;
        MASK_OFS: next_r.rdata[IRQ_W-1:0] = r.irq_mask;
        default: map_r = 1'b0;
      endcase
      next_r.rresp = map_r ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready_in) begin
      next_r.rvalid = 1'b0;
    end

    // pwm engine
    next_r.run_prev = pwm_run_input_in;
    unique case (r.state)
      CRP_IDLE: begin
        next_r.pin = 1'b0;
        next_r.cnt = '0;
        if (pwm_run_input_in && !r.run_prev) begin
          if (duty_bad) begin
            next_r.state = CRP_FAULT; // RULE7
            irq_set[IRQ_ERR] = 1'b1; // RULE7
          end else begin
            next_r.state = CRP_RUN; // RULE5
            next_r.period = rom_period; // RULE3
            next_r.high = calc_high; // RULE9
          end
        end
      end
      CRP_RUN: begin
        if (!pwm_run_input_in) begin
          next_r.state = CRP_IDLE; // RULE5
          next_r.pin = 1'b0;
        end else begin
          next_r.pin = (r.cnt < r.high); // RULE9 RULE4
          if (r.cnt >= r.period - CNT_W'(1)) begin
            next_r.cnt = '0;
            next_r.period = rom_period; // RULE3
            next_r.high = calc_high; // RULE6
            irq_set[IRQ_WRAP] = 1'b1;
          end else begin
            next_r.cnt = r.cnt + CNT_W'(1);
          end
        end
      end
      CRP_FAULT: begin
        next_r.pin = 1'b0;
        if (!pwm_run_input_in) next_r.state = CRP_IDLE;
      end
      default: next_r.state = CRP_IDLE;
    endcase
    // set wins over clear
    next_r.irq_stat = next_r.irq_stat | irq_set;
    next_r.hi_len = next_r.pin ? r.hi_len + CNT_W'(1) : '0;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.state <= CRP_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_bvalid_out = r.bvalid;
  assign s_axi_bresp_out = r.bresp;
  assign s_axi_rvalid_out = r.rvalid;
  assign s_axi_rdata_out = r.rdata;
  assign s_axi_rresp_out = r.rresp;
  assign pwm_output_pin_out = r.pin && r.pin_enable; // RULE8
  assign irq_out = |(r.irq_stat & r.irq_mask);

  a_stop_no_pulse: assert property ( // RULE5
    @(posedge core_clk_in) disable iff (!resetn_in)
    !pwm_run_input_in |=> !r.pin)
    else $error("pin high after run dropped");
  a_bad_start_err: assert property ( // RULE7
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_IDLE && pwm_run_input_in && !r.run_prev && duty_bad)
    |=> (r.state == CRP_FAULT && r.irq_stat[IRQ_ERR]))
    else $error("bad start not faulted");
  a_good_start_run: assert property ( // RULE5
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_IDLE && pwm_run_input_in && !r.run_prev && !duty_bad)
    |=> r.state == CRP_RUN)
    else $error("good start did not run");
  a_run_keeps: assert property ( // RULE6
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_RUN && pwm_run_input_in) |=> r.state == CRP_RUN)
    else $error("running channel stopped");
  a_clamp_max: assert property ( // RULE6
    @(posedge core_clk_in) disable iff (!resetn_in)
    eff_duty <= max_duty)
    else $error("duty not clamped");
  a_fine_range: assert property ( // RULE1
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.code <= LAST_FINE_CODE) |-> max_duty == 10'h3e7)
    else $error("fine max wrong");
  a_coarse_step: assert property ( // RULE2
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.code > LAST_FINE_CODE) |-> (eff_duty % 10'h00a) == 10'h000)
    else $error("coarse duty not whole percent");
  a_high_le_per: assert property ( // RULE9
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.state == CRP_RUN |-> r.high < r.period)
    else $error("high time exceeds period");
  a_code1_period: assert property ( // RULE4
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.code == 5'h01 |-> rom_period == 28'h77cec6c)
    else $error("code 1 period wrong");
  a_irq_level: assert property ( // RULE7
    @(posedge core_clk_in) disable iff (!resetn_in)
    $rose(r.irq_stat[IRQ_ERR]) && r.irq_mask[IRQ_ERR] |-> irq_out)
    else $error("masked-in event missing irq");
  a_high_bound: assert property ( // RULE9
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.hi_len <= r.high)
    else $error("pulse longer than high time");
  a_high_exact: assert property ( // RULE9
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_RUN && pwm_run_input_in && r.pin && !next_r.pin) |-> r.hi_len == r.high)
    else $error("pulse width differs from high time");
  a_pin_only_run: assert property ( // RULE5
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.pin |-> r.state == CRP_RUN)
    else $error("pin high outside run");
  a_run_to_idle: assert property ( // RULE5
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_RUN && !pwm_run_input_in) |=> r.state == CRP_IDLE)
    else $error("channel kept running after run dropped");
  a_fault_no_pin: assert property ( // RULE7
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.state == CRP_FAULT |-> !r.pin)
    else $error("pin high in fault");
  a_fault_holds: assert property ( // RULE7
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_FAULT && pwm_run_input_in) |=> r.state == CRP_FAULT)
    else $error("fault left while run held");
  a_err_sticky: assert property ( // RULE7
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.irq_stat[IRQ_ERR] && !(wr_fire && r.aw_addr == IRQ_OFS)) |=> r.irq_stat[IRQ_ERR])
    else $error("error flag lost without clear");
  a_cnt_in_period: assert property ( // RULE3
    @(posedge core_clk_in) disable iff (!resetn_in)
    r.state == CRP_RUN |-> r.cnt < r.period)
    else $error("counter beyond period");
  a_fine_exact: assert property ( // RULE1
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.code <= LAST_FINE_CODE && r.duty <= 10'h3e7) |-> eff_duty == r.duty)
    else $error("fine duty altered");
  a_coarse_max: assert property ( // RULE2
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.code > LAST_FINE_CODE) |-> max_duty == 10'h3de)
    else $error("coarse max wrong");
  a_clamp_run: assert property ( // RULE6
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.duty > max_duty) |-> eff_duty == max_duty)
    else $error("out of range duty not set to max");
  a_pin_gated: assert property ( // RULE8
    @(posedge core_clk_in) disable iff (!resetn_in)
    !r.pin_enable |-> !pwm_output_pin_out)
    else $error("pin driven while not assigned");
  a_wrap_flag: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.state == CRP_RUN && pwm_run_input_in && r.cnt == r.period - CNT_W'(1))
    |=> r.irq_stat[IRQ_WRAP])
    else $error("period wrap flag missing");
  a_write_answer: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (r.aw_got && r.w_got) |=> s_axi_bvalid_out)
    else $error("write response missing");
  a_write_block: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted during response");
  a_read_answer: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_arvalid_in && s_axi_arready_out) |=> s_axi_rvalid_out)
    else $error("read data missing");
  a_read_block: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted during data");
  a_slverr_zero: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR) |-> s_axi_rdata_out == 32'h0)
    else $error("refused read returned data");
endmodule : crp_pwm_top

//--- verif/crp_load_model.sv
`timescale 1ns/10ps
module crp_load_model (
  // clock and pin
  input wire logic core_clk_in,
  input wire logic pwm_in,
  // last pulse width, last period and rise count in clock cycles
  output logic [31:0] high_out,
  output logic [31:0] period_out,
  output logic [31:0] rises_out
);
  logic [31:0] cnt = 0;
  logic prev = 0;
  initial begin
    high_out = 0;
    period_out = 0;
    rises_out = 0;
  end
  // passive load: only observes the pin
  always @(posedge core_clk_in) begin
    prev <= pwm_in;
    cnt <= cnt + 1;
    if (pwm_in && !prev) begin
      period_out <= cnt;
      rises_out <= rises_out + 1;
      cnt <= 32'h1;
    end
    if (!pwm_in && prev) begin
      high_out <= cnt;
    end
  end
endmodule : crp_load_model

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import crp_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic run = 0;
  logic [7:0] awa = 0;
  logic [7:0] ara = 0;
  logic [31:0] wd = 0;
  logic awv = 0;
  logic wv = 0;
  logic arv = 0;
  logic awr, wr_rdy, bv, arr, rv, pin, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, high, per, rises;
  int n_fail = 0;
  int total_checks = 0;
  crp_pwm_top i_crp_pwm_top (
    .core_clk_in(clk), .resetn_in(rstn), .pwm_run_input_in(run),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .pwm_output_pin_out(pin),
    .irq_out(irq));
  crp_load_model i_crp_load_model (.core_clk_in(clk), .pwm_in(pin),
    .high_out(high), .period_out(per), .rises_out(rises));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr_rdy;
      tb = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    chk({30'h0, r}, {30'h0, er}, "bresp");
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    chk({30'h0, r}, {30'h0, er}, "rresp");
    chk(d & m, e, "rdata");
  endtask : rdc
  function automatic logic [31:0] cyc(input int c);
    return PERIOD_NS[c] / CLK_PERIOD_NS;
  endfunction : cyc
  task automatic start(input logic [4:0] c, input logic [9:0] d);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    wr(CODE_OFS, {27'h0, c}, RESP_OKAY);
    wr(DUTY_OFS, {22'h0, d}, RESP_OKAY);
    run <= 1'b1;
    @(posedge clk);
  endtask : start
  task automatic stop;
    run <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, pin}, 32'h0, "pin after stop");
    @(posedge clk);
  endtask : stop
  task automatic wait_rises(input int k);
    int e;
    e = rises;
    while (rises < e + k) @(posedge clk);
    @(posedge clk);
  endtask : wait_rises
  task automatic t_regs;
    rdc(CTRL_OFS, 32'hffffffff, 32'h0, RESP_OKAY);
    rdc(STAT_OFS, 32'h3, 32'h0, RESP_OKAY);
    rdc(IRQ_OFS, 32'h3, 32'h0, RESP_OKAY);
    rdc(8'h40, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(MASK_OFS, 32'h3, RESP_OKAY);
    rdc(MASK_OFS, 32'h3, 32'h3, RESP_OKAY);
    wr(MASK_OFS, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs
  task automatic t_coarse;
    start(5'd22, 10'd257);
    wait_rises(2);
    chk(per, cyc(22), "coarse period");
    chk(high, cyc(22) * 250 / 1000, "coarse high");
    rdc(STAT_OFS, 32'h7, 32'h1, RESP_OKAY);
    stop();
    $display("test coarse done");
  endtask : t_coarse
  task automatic t_fine;
    start(5'd19, 10'd999);
    wait_rises(2);
    chk(per, cyc(19), "fine period");
    chk(high, cyc(19) * 999 / 1000, "fine high");
    rdc(STAT_OFS, 32'h7, 32'h5, RESP_OKAY);
    stop();
    $display("test fine done");
  endtask : t_fine
  task automatic t_clamp;
    start(5'd24, 10'd500);
    wr(DUTY_OFS, 32'h3ff, RESP_OKAY);
    wait_rises(3);
    chk(high, cyc(24) * 990 / 1000, "clamped high");
    rdc(STAT_OFS, 32'h3, 32'h1, RESP_OKAY);
    stop();
    $display("test clamp done");
  endtask : t_clamp
  task automatic t_fault;
    int e;
    wr(IRQ_OFS, 32'h3, RESP_OKAY);
    wr(MASK_OFS, 32'h1, RESP_OKAY);
    e = rises;
    start(5'd0, 10'd1000);
    repeat (20) @(posedge clk);
    chk(rises, e, "no pulses on fault");
    rdc(STAT_OFS, 32'h3, 32'h2, RESP_OKAY);
    rdc(IRQ_OFS, 32'h1, 32'h1, RESP_OKAY);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(MASK_OFS, 32'h0, RESP_OKAY);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    @(posedge clk);
    wr(IRQ_OFS, 32'h1, RESP_OKAY);
    rdc(IRQ_OFS, 32'h1, 32'h0, RESP_OKAY);
    stop();
    $display("test fault done");
  endtask : t_fault
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_coarse();
    t_fine();
    t_clamp();
    t_fault();
    final_report();
  end
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
endmodule : testbench
